/* msa_pkg.sv */
// Purpose: constants for the monitor status and alarm register bank
// Assumes: byte-wide registers, two receiver copies
// Notes: offsets are register addresses within a slave address
package msa_pkg;
    localparam int MSA_COPIES = 2;
    localparam logic [7:0] MSA_ADDR_STATUS = 8'h6E;
    localparam logic [7:0] MSA_ADDR_UPDATE = 8'h6F;
    localparam logic [7:0] MSA_ADDR_ALARM = 8'h70;
    localparam logic [7:0] MSA_UPDATE_RESET = 8'h00;
    localparam logic [7:0] MSA_ALARM_RESET = 8'h10;
    localparam logic [7:0] MSA_UPDATE_MASK = 8'hC9;
    localparam logic [7:0] MSA_ALARM_MASK = 8'hF0;
    localparam int MSA_BIT_FAULT = 2;
    localparam int MSA_BIT_RXLOSS = 1;
    localparam int MSA_BIT_READY_BAR = 0;
    localparam int MSA_BIT_TEMP_RDY = 7;
    localparam int MSA_BIT_VCC_RDY = 6;
    localparam int MSA_BIT_RX_RDY = 3;
    localparam int MSA_BIT_RANGE = 0;
    localparam int MSA_BIT_TEMPERATURE_HIGH_ALARM = 7;
    localparam int MSA_BIT_TEMPERATURE_LOW_ALARM = 6;
    localparam int MSA_BIT_SUPPLY_HIGH_ALARM = 5;
    localparam int MSA_BIT_SUPPLY_LOW_ALARM = 4;
endpackage

/* msa_regs.sv */
// Purpose: status, conversion-update and temperature/supply alarm registers
// Assumes: bus slave decodes slave address into bus_sel and hands byte accesses here
// Notes: bus_sel 0 is the receiver 1 copy, 1 the receiver 2 copy
//
// Operation
// (RULE1) status bit 2 reads back the level driven on the fault pin
// (RULE2) status bit 1 shows loss pin or fast low flag, chosen by source select
// (RULE3) status bit 0 reads 1 while supply is below analog trip, else 0
// (RULE4) ready flags clear at power-on, set when their conversion completes
// (RULE5) host may clear ready flags; they stay clear until next completion; here a bus write of 1 to a ready bit also sets it
// (RULE6) update register written by bus and hardware, powers on as zero
// (RULE7) update and alarm registers exist once per receiver, picked by slave address
// (RULE8) range flag shows fine (0) or coarse (1) range of latest power result
// (RULE9) temperature high alarm is 1 when last result exceeded high threshold
// (RULE10) temperature low alarm is 1 when last result fell below low threshold
// (RULE11) supply high alarm is 1 when last result exceeded high threshold
// (RULE12) supply low alarm forced to 1 while supply is below analog trip
// (RULE13) supply low alarm follows last result, clearing when above low threshold
// (RULE14) alarm register powers on with only supply low alarm set
// (RULE15) reserved bits read zero and ignore writes
// (RULE16) alarm and range flags update in the same cycle as their result
`timescale 1ns/1ps
module msa_regs
    import msa_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register access
    input wire logic bus_sel,
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic bus_rvalid,
    // pins and internal status
    input wire logic fault_pin_level,
    input wire logic [1:0] signal_loss_input,
    input wire logic [1:0] fast_low_signal_flag,
    input wire logic loss_source_select,
    input wire logic analog_power_on_trip,
    // conversion results
    input wire logic temp_done,
    input wire logic temp_above_hi,
    input wire logic temp_below_lo,
    input wire logic vcc_done,
    input wire logic vcc_above_hi,
    input wire logic vcc_below_lo,
    input wire logic [1:0] rx_power_done,
    input wire logic [1:0] rx_power_coarse
);
    import msa_pkg::*;

    logic [1:0][2:0] los_sync_reg, los_sync_next;
    logic [1:0] los_stable_reg, los_stable_next;
    logic [2:0] trip_sync_reg, trip_sync_next;
    logic trip_stable_reg, trip_stable_next;
    logic [1:0][7:0] upd_reg, upd_next;
    logic [1:0][7:0] alm_reg, alm_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic rxl_sel;

    // pin synchronisers, change accepted when stages two and three agree
    always_comb begin
        for (int i = 0; i < MSA_COPIES; i++) begin
            los_sync_next[i] = {los_sync_reg[i][1:0], signal_loss_input[i]};
            los_stable_next[i] = los_stable_reg[i];
            if (los_sync_reg[i][1] == los_sync_reg[i][2]) begin
                los_stable_next[i] = los_sync_reg[i][2];
            end
        end
        trip_sync_next = {trip_sync_reg[1:0], analog_power_on_trip};
        trip_stable_next = trip_stable_reg;
        if (trip_sync_reg[1] == trip_sync_reg[2]) begin
            trip_stable_next = trip_sync_reg[2];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            los_sync_reg <= '0;
            los_stable_reg <= '0;
            trip_sync_reg <= 3'h7;
            trip_stable_reg <= 1'b1;
        end else begin
            los_sync_reg <= los_sync_next;
            los_stable_reg <= los_stable_next;
            trip_sync_reg <= trip_sync_next;
            trip_stable_reg <= trip_stable_next;
        end
    end

    // per-receiver update and alarm registers
    always_comb begin
        for (int i = 0; i < MSA_COPIES; i++) begin
            upd_next[i] = upd_reg[i];
            alm_next[i] = alm_reg[i];
            if (bus_wr && (bus_sel == i[0]) && (bus_addr == MSA_ADDR_UPDATE)) begin // see (RULE7)
                upd_next[i] = bus_wdata & MSA_UPDATE_MASK; // see (RULE5) see (RULE6) see (RULE15)
            end
            if (temp_done) begin
                upd_next[i][MSA_BIT_TEMP_RDY] = 1'b1; // see (RULE4)
                alm_next[i][MSA_BIT_TEMPERATURE_HIGH_ALARM] = temp_above_hi; // see (RULE9) see (RULE16)
                alm_next[i][MSA_BIT_TEMPERATURE_LOW_ALARM] = temp_below_lo; // see (RULE10)
            end
            if (vcc_done) begin
                upd_next[i][MSA_BIT_VCC_RDY] = 1'b1; // see (RULE4)
                alm_next[i][MSA_BIT_SUPPLY_HIGH_ALARM] = vcc_above_hi; // see (RULE11)
                alm_next[i][MSA_BIT_SUPPLY_LOW_ALARM] = vcc_below_lo; // see (RULE13)
            end
            if (rx_power_done[i]) begin
                upd_next[i][MSA_BIT_RX_RDY] = 1'b1; // see (RULE4)
                upd_next[i][MSA_BIT_RANGE] = rx_power_coarse[i]; // see (RULE8) see (RULE16)
            end
            if (trip_stable_reg) begin
                alm_next[i][MSA_BIT_SUPPLY_LOW_ALARM] = 1'b1; // see (RULE12)
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            upd_reg <= {MSA_UPDATE_RESET, MSA_UPDATE_RESET}; // see (RULE6)
            alm_reg <= {MSA_ALARM_RESET, MSA_ALARM_RESET}; // see (RULE14)
        end else begin
            upd_reg <= upd_next;
            alm_reg <= alm_next;
        end
    end

    // read path, answer one cycle after the read strobe
    always_comb begin
        rxl_sel = loss_source_select ? fast_low_signal_flag[bus_sel] : los_stable_reg[bus_sel]; // see (RULE2)
        rdata_next = rdata_reg;
        rvalid_next = bus_rd;
        if (bus_rd) begin
            rdata_next = 8'h00;
            if (bus_addr == MSA_ADDR_STATUS) begin
                rdata_next[MSA_BIT_FAULT] = fault_pin_level; // see (RULE1)
                rdata_next[MSA_BIT_RXLOSS] = rxl_sel;
                rdata_next[MSA_BIT_READY_BAR] = trip_stable_reg; // see (RULE3)
            end else if (bus_addr == MSA_ADDR_UPDATE) begin
                rdata_next = upd_reg[bus_sel] & MSA_UPDATE_MASK; // see (RULE15)
            end else if (bus_addr == MSA_ADDR_ALARM) begin
                rdata_next = alm_reg[bus_sel] & MSA_ALARM_MASK;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign bus_rvalid = rvalid_reg;

    // register behaviour checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_fault_read_back: assert property (bus_rd && bus_addr == MSA_ADDR_STATUS |=> // see (RULE1)
        bus_rdata[MSA_BIT_FAULT] == $past(fault_pin_level)) else $error("fault readback wrong");
    a_rx_loss_source: assert property (bus_rd && bus_addr == MSA_ADDR_STATUS && !bus_sel |=> // see (RULE2)
        bus_rdata[MSA_BIT_RXLOSS] == ($past(loss_source_select) ? $past(fast_low_signal_flag[0])
        : $past(los_stable_reg[0]))) else $error("rx loss status wrong");
    a_rx_loss_copy2: assert property (bus_rd && bus_addr == MSA_ADDR_STATUS && bus_sel |=> // see (RULE2)
        bus_rdata[MSA_BIT_RXLOSS] == ($past(loss_source_select) ? $past(fast_low_signal_flag[1])
        : $past(los_stable_reg[1]))) else $error("rx loss status wrong on copy two");
    a_ready_bar_level: assert property (bus_rd && bus_addr == MSA_ADDR_STATUS |=> // see (RULE3)
        bus_rdata[MSA_BIT_READY_BAR] == $past(trip_stable_reg)) else $error("ready bar wrong");
    a_status_reserved: assert property (bus_rd && bus_addr == MSA_ADDR_STATUS |=> // see (RULE15)
        bus_rdata[7:3] == 5'h00) else $error("status upper bits not zero");
    a_temp_ready_set: assert property (temp_done |=> // see (RULE4)
        upd_reg[0][MSA_BIT_TEMP_RDY] && upd_reg[1][MSA_BIT_TEMP_RDY]) else $error("temp ready not set");
    a_vcc_ready_set: assert property (vcc_done |=> // see (RULE4)
        upd_reg[0][MSA_BIT_VCC_RDY] && upd_reg[1][MSA_BIT_VCC_RDY]) else $error("supply ready not set");
    a_rx_ready_set: assert property (rx_power_done[0] |=> // see (RULE4)
        upd_reg[0][MSA_BIT_RX_RDY]) else $error("power ready not set");
    a_ready_stays_clear: assert property (bus_wr && !bus_sel && bus_addr == MSA_ADDR_UPDATE // see (RULE5)
        && !bus_wdata[MSA_BIT_VCC_RDY] && !vcc_done ##1 (!(vcc_done || (bus_wr && !bus_sel))) [*3]
        |-> !upd_reg[0][MSA_BIT_VCC_RDY]) else $error("ready flag set without conversion");
    a_update_write: assert property (bus_wr && !bus_sel && bus_addr == MSA_ADDR_UPDATE // see (RULE6)
        && !temp_done && !vcc_done && !rx_power_done[0] |=> upd_reg[0] == ($past(bus_wdata) & MSA_UPDATE_MASK))
        else $error("update write wrong");
    a_copy_isolated: assert property (bus_wr && bus_sel && !rx_power_done[0] |=> // see (RULE7)
        upd_reg[0][MSA_BIT_RANGE] == $past(upd_reg[0][MSA_BIT_RANGE])) else $error("wrong copy written");
    a_update_copy_sel: assert property (bus_wr && bus_sel && bus_addr == MSA_ADDR_UPDATE // see (RULE7)
        && !temp_done && !vcc_done && !rx_power_done[1] |=> upd_reg[1] == ($past(bus_wdata) & MSA_UPDATE_MASK))
        else $error("update write missed copy two");
    a_range_follows: assert property (rx_power_done[1] |=> // see (RULE8)
        upd_reg[1][MSA_BIT_RANGE] == $past(rx_power_coarse[1]) && upd_reg[1][MSA_BIT_RX_RDY])
        else $error("range flag wrong");
    a_range_copy_one: assert property (rx_power_done[0] |=> // see (RULE8)
        upd_reg[0][MSA_BIT_RANGE] == $past(rx_power_coarse[0])) else $error("range flag wrong on copy one");
    a_temp_alarms: assert property (temp_done |=> alm_reg[0][MSA_BIT_TEMPERATURE_HIGH_ALARM] == $past(temp_above_hi) // see (RULE9)
        && alm_reg[1][MSA_BIT_TEMPERATURE_LOW_ALARM] == $past(temp_below_lo)) else $error("temp alarm wrong");
    a_temp_alarms_swap: assert property (temp_done |=> // see (RULE10)
        alm_reg[1][MSA_BIT_TEMPERATURE_HIGH_ALARM] == $past(temp_above_hi)
        && alm_reg[0][MSA_BIT_TEMPERATURE_LOW_ALARM] == $past(temp_below_lo)) else $error("temp alarm wrong on other copy");
    a_vcc_high_alarm: assert property (vcc_done |=> // see (RULE11)
        alm_reg[0][MSA_BIT_SUPPLY_HIGH_ALARM] == $past(vcc_above_hi)) else $error("supply high alarm wrong");
    a_vcc_high_copy: assert property (vcc_done |=> // see (RULE11)
        alm_reg[1][MSA_BIT_SUPPLY_HIGH_ALARM] == $past(vcc_above_hi)) else $error("supply high alarm wrong on copy two");
    a_vcc_low_forced: assert property (trip_stable_reg |=> // see (RULE12)
        alm_reg[0][MSA_BIT_SUPPLY_LOW_ALARM] && alm_reg[1][MSA_BIT_SUPPLY_LOW_ALARM]) else $error("supply low not forced");
    a_vcc_low_clears: assert property (vcc_done && !vcc_below_lo && !trip_stable_reg |=> // see (RULE13)
        !alm_reg[1][MSA_BIT_SUPPLY_LOW_ALARM]) else $error("supply low did not clear");
    a_vcc_low_result: assert property (vcc_done && !trip_stable_reg |=> // see (RULE13)
        alm_reg[0][MSA_BIT_SUPPLY_LOW_ALARM] == $past(vcc_below_lo)) else $error("supply low alarm wrong");
    a_alarm_not_written: assert property (bus_wr && bus_addr == MSA_ADDR_ALARM // see (RULE15)
        && !temp_done && !vcc_done && !trip_stable_reg |=> alm_reg == $past(alm_reg))
        else $error("alarm register took a write");
    a_reserved_zero: assert property (bus_rd && bus_addr == MSA_ADDR_ALARM |=> // see (RULE15)
        (bus_rdata & ~MSA_ALARM_MASK) == 8'h00) else $error("reserved bits not zero");
    a_update_reserved: assert property (bus_rd && bus_addr == MSA_ADDR_UPDATE |=> // see (RULE15)
        (bus_rdata & ~MSA_UPDATE_MASK) == 8'h00) else $error("update reserved bits not zero");
endmodule

/* msa_host.sv */
// Purpose: host model issuing byte reads and writes to the register bank
// Assumes: pre-decoded byte port, strobes driven at the falling edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module msa_host (
    // clock
    input wire logic mclk,
    // register access
    output logic bus_sel,
    output logic [7:0] bus_addr,
    output logic bus_wr,
    output logic [7:0] bus_wdata,
    output logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_rvalid
);
    initial begin
        bus_sel = 1'b0;
        bus_addr = 8'h00;
        bus_wr = 1'b0;
        bus_wdata = 8'h00;
        bus_rd = 1'b0;
    end
    task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        bus_sel = s;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge mclk);
        bus_wr = 1'b0;
        bus_addr = ~a;
        bus_wdata = ~d;
    endtask
    task automatic rd(input logic s, input logic [7:0] a, output logic [7:0] q, output logic v);
        @(negedge mclk);
        bus_sel = s;
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge mclk);
        q = bus_rdata;
        v = bus_rvalid;
        bus_rd = 1'b0;
        bus_addr = ~a;
    endtask
endmodule

/* monitor_status_alarm_regs_bench.sv */
// Purpose: self-checking bench for the status and alarm register bank
// Assumes: 25 MHz clock, inputs driven at the falling edge
// Notes: row table holds comparison inputs and expected alarm byte
`timescale 1ns/1ps
module monitor_status_alarm_regs_bench;
    import msa_pkg::*;
    logic mclk, resetn, bus_sel, bus_wr, bus_rd, bus_rvalid, fault_pin_level, loss_source_select;
    logic analog_power_on_trip, temp_done, temp_above_hi, temp_below_lo, vcc_done, vcc_above_hi, vcc_below_lo;
    logic [1:0] signal_loss_input, fast_low_signal_flag, rx_power_done, rx_power_coarse;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic [15:0] rows [4] = '{16'h15A0, 16'h0A50, 16'h0100, 16'h1CE0};
    int failures, checks_done;
    msa_regs msa_regs_inst (.mclk, .resetn, .bus_sel, .bus_addr, .bus_wr, .bus_wdata, .bus_rd, .bus_rdata,
        .bus_rvalid, .fault_pin_level, .signal_loss_input, .fast_low_signal_flag, .loss_source_select,
        .analog_power_on_trip, .temp_done, .temp_above_hi, .temp_below_lo, .vcc_done, .vcc_above_hi,
        .vcc_below_lo, .rx_power_done, .rx_power_coarse);
    msa_host msa_host_inst (.mclk, .bus_sel, .bus_addr, .bus_wr, .bus_wdata, .bus_rd, .bus_rdata, .bus_rvalid);
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rc(input logic s, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic v;
        msa_host_inst.rd(s, a, q, v);
        chk("read valid", {7'h00, v}, 8'h01);
        chk($sformatf("reg %h copy %0d", a, s), q, exp);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        {resetn, temp_done, temp_above_hi, temp_below_lo, vcc_done, vcc_above_hi, vcc_below_lo} = 7'h00;
        {rx_power_done, rx_power_coarse, analog_power_on_trip, signal_loss_input} = 7'h02;
        {fault_pin_level, loss_source_select, fast_low_signal_flag} = 4'hD;
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        rc(0, MSA_ADDR_ALARM, 8'h10);
        rc(1, MSA_ADDR_UPDATE, 8'h00);
        repeat (4) @(negedge mclk);
        rc(0, MSA_ADDR_STATUS, 8'h06);
        rc(1, MSA_ADDR_STATUS, 8'h04);
        foreach (rows[i]) begin
            @(negedge mclk);
            {temp_above_hi, temp_below_lo, vcc_above_hi, vcc_below_lo} = rows[i][12:9];
            rx_power_coarse = {~rows[i][8], rows[i][8]};
            {temp_done, vcc_done, rx_power_done} = 4'hF;
            @(negedge mclk);
            {temp_done, vcc_done, rx_power_done} = 4'h0;
            rc(0, MSA_ADDR_ALARM, rows[i][7:0]);
            rc(0, MSA_ADDR_UPDATE, 8'hC8 | {7'h00, rows[i][8]});
            rc(1, MSA_ADDR_UPDATE, 8'hC8 | {7'h00, ~rows[i][8]});
            msa_host_inst.wr(0, MSA_ADDR_UPDATE, 8'h01);
            msa_host_inst.wr(1, MSA_ADDR_UPDATE, 8'h00);
        end
        rc(0, MSA_ADDR_UPDATE, 8'h01);
        rc(1, MSA_ADDR_UPDATE, 8'h00);
        msa_host_inst.wr(0, MSA_ADDR_UPDATE, 8'hFF);
        rc(0, MSA_ADDR_UPDATE, 8'hC9);
        msa_host_inst.wr(0, MSA_ADDR_ALARM, 8'h0F);
        rc(0, MSA_ADDR_ALARM, 8'hE0);
        rc(0, 8'h71, 8'h00);
        loss_source_select = 1'b0;
        fault_pin_level = 1'b0;
        analog_power_on_trip = 1'b1;
        repeat (6) @(negedge mclk);
        rc(0, MSA_ADDR_ALARM, 8'hF0);
        rc(0, MSA_ADDR_STATUS, 8'h01);
        rc(1, MSA_ADDR_STATUS, 8'h03);
        resetn = 1'b0;
        @(negedge mclk);
        resetn = 1'b1;
        rc(0, MSA_ADDR_UPDATE, 8'h00);
        rc(1, MSA_ADDR_ALARM, 8'h10);
        end_sim();
    end
endmodule
